// ===== core/palm_cfg_if.sv
// Interface carrying configuration from the register holder to the mux logic.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface palm_cfg_if;
    import palm_pkg::*;
    palm_code_t padSel [PALM_PINS];
    palm_code_t route [PALM_ROUTES];
    logic [PALM_PINS-1:0] traceOwn;
    modport regs (output padSel, output route, output traceOwn);
    modport mux (input padSel, input route, input traceOwn);
endinterface

// ===== core/palm_cfg_regs.sv
// Pad select and input route registers, written by plain load strobes.
// Assumes write strobes are synchronous one-cycle pulses.
`timescale 1ns/1ps
module palm_cfg_regs
    import palm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [PALM_PINS-1:0] padWe,
    input wire logic [PALM_CODE_W-1:0] padWdata,
    input wire logic [PALM_ROUTES-1:0] routeWe,
    input wire logic [PALM_CODE_W-1:0] routeWdata,
    input wire logic traceConnected,
    input wire logic [PALM_PINS-1:0] traceMask,
    palm_cfg_if.regs cfg
);
    palm_code_t pad_reg [PALM_PINS];
    palm_code_t pad_next [PALM_PINS];
    palm_code_t route_reg [PALM_ROUTES];
    palm_code_t route_next [PALM_ROUTES];
    palm_mode_e mode_reg, mode_next;

    always_comb begin
        for (int i = 0; i < PALM_PINS; i++) begin
            pad_next[i] = padWe[i] ? padWdata : pad_reg[i]; // R1
        end
        for (int j = 0; j < PALM_ROUTES; j++) begin
            route_next[j] = routeWe[j] ? routeWdata : route_reg[j]; // R2
        end
        mode_next = traceConnected ? PALM_TRACE : PALM_NORMAL;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < PALM_PINS; i++) pad_reg[i] <= PALM_PAD_RST;
            for (int j = 0; j < PALM_ROUTES; j++) route_reg[j] <= PALM_RT_RST;
            mode_reg <= PALM_NORMAL;
        end else begin
            pad_reg <= pad_next;
            route_reg <= route_next;
            mode_reg <= mode_next;
        end
    end

    assign cfg.padSel = pad_reg;
    assign cfg.route = route_reg;
    assign cfg.traceOwn = (mode_reg == PALM_TRACE) ? traceMask : '0; // R3

    a_pad_write: assert property (@(posedge clk) disable iff (sys_rst)
        padWe[0] |=> pad_reg[0] == $past(padWdata)) else $error("pad write lost"); // R1
    a_route_write: assert property (@(posedge clk) disable iff (sys_rst)
        routeWe[0] |=> route_reg[0] == $past(routeWdata)) else $error("route write lost"); // R2
endmodule

// ===== core/palm_mux_core.sv
// Combinational pin output select and peripheral input route.
// Assumes configuration is stable registered state.
`timescale 1ns/1ps
module palm_mux_core
    import palm_pkg::*;
(
    palm_cfg_if.mux cfg,
    input wire logic [PALM_PINS-1:0] gpioOut,
    input wire logic [PALM_PINS-1:0] gpioOe,
    input wire logic [PALM_PINS-1:0] alt1Out,
    input wire logic [PALM_PINS-1:0] alt1Oe,
    input wire logic [PALM_PINS-1:0] alt2Out,
    input wire logic [PALM_PINS-1:0] alt2Oe,
    input wire logic [PALM_PINS-1:0] alt3Out,
    input wire logic [PALM_PINS-1:0] alt3Oe,
    input wire logic [PALM_PINS-1:0] traceOut,
    input wire logic [PALM_PINS-1:0] padIn,
    output logic [PALM_PINS-1:0] pinOut,
    output logic [PALM_PINS-1:0] pinDrive,
    output logic [PALM_ROUTES-1:0] periphIn
);
    // Pins with a documented function at each code.
    localparam logic [PALM_PINS-1:0] HAS_ALT1 = 4'hf;
    localparam logic [PALM_PINS-1:0] HAS_ALT2 = 4'hb;
    localparam logic [PALM_PINS-1:0] HAS_ALT3 = 4'hc;

    function automatic logic routeHit(palm_code_t code, palm_code_t want);
        return code == want;
    endfunction

    genvar g;
    generate
        for (g = 0; g < PALM_PINS; g++) begin : gPin
            always_comb begin
                pinOut[g] = 1'b0;
                pinDrive[g] = 1'b0;
                if (cfg.traceOwn[g]) begin
                    pinOut[g] = traceOut[g]; // R3
                    pinDrive[g] = 1'b1;
                end else begin
                    case (cfg.padSel[g]) // R4 R6 R8 R11
                        PALM_PAD_GPIO: begin
                            pinOut[g] = gpioOut[g];
                            pinDrive[g] = gpioOe[g];
                        end
                        PALM_PAD_ALT1: begin
                            pinOut[g] = alt1Out[g] & HAS_ALT1[g];
                            pinDrive[g] = alt1Oe[g] & HAS_ALT1[g];
                        end
                        PALM_PAD_ALT2: begin
                            pinOut[g] = alt2Out[g] & HAS_ALT2[g];
                            pinDrive[g] = alt2Oe[g] & HAS_ALT2[g];
                        end
                        PALM_PAD_ALT3: begin
                            pinOut[g] = alt3Out[g] & HAS_ALT3[g];
                            pinDrive[g] = alt3Oe[g] & HAS_ALT3[g];
                        end
                        default: begin
                            pinOut[g] = 1'b0; // R14
                            pinDrive[g] = 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    always_comb begin
        periphIn[RT_SCK_IN] = routeHit(cfg.route[RT_SCK_IN], PALM_RT_C1) & padIn[0]; // R5
        periphIn[RT_TMR0_IN] = routeHit(cfg.route[RT_TMR0_IN], PALM_RT_C2) & padIn[0]; // R5
        periphIn[RT_IRQ0] = routeHit(cfg.route[RT_IRQ0], PALM_RT_C1) & padIn[0]; // R5
        periphIn[RT_TMR1_IN] = routeHit(cfg.route[RT_TMR1_IN], PALM_RT_C2) & padIn[1]; // R7
        periphIn[RT_IRQ1] = routeHit(cfg.route[RT_IRQ1], PALM_RT_C1) & padIn[1]; // R7
        periphIn[RT_BOOT1] = routeHit(cfg.route[RT_BOOT1], PALM_RT_OFF) & padIn[2]; // R9
        periphIn[RT_SDI] = routeHit(cfg.route[RT_SDI], PALM_RT_C2) & padIn[2]; // R10
        periphIn[RT_TMR2_IN] = routeHit(cfg.route[RT_TMR2_IN], PALM_RT_C2) & padIn[2]; // R10
        periphIn[RT_PWMA3_IN] = routeHit(cfg.route[RT_PWMA3_IN], PALM_RT_C1) & padIn[2]; // R10
        periphIn[RT_IRQ2] = routeHit(cfg.route[RT_IRQ2], PALM_RT_C1) & padIn[2]; // R10
        periphIn[RT_BOOT2] = routeHit(cfg.route[RT_BOOT2], PALM_RT_OFF) & padIn[3]; // R12
        periphIn[RT_TMR3_IN] = routeHit(cfg.route[RT_TMR3_IN], PALM_RT_C2) & padIn[3]; // R12
        periphIn[RT_CSEL_IN] = routeHit(cfg.route[RT_CSEL_IN], PALM_RT_C1) & padIn[3]; // R13
        periphIn[RT_PWMB3_IN] = routeHit(cfg.route[RT_PWMB3_IN], PALM_RT_C1) & padIn[3]; // R13
        periphIn[RT_IRQ3] = routeHit(cfg.route[RT_IRQ3], PALM_RT_C1) & padIn[3]; // R13
    end
endmodule

// ===== core/palm_pkg.sv
// Package for the port A low pin multiplexer: source codes, reset values, sizes.
// Assumes a single synchronous clock domain and plain configuration ports.
package palm_pkg;
    localparam int PALM_PINS = 4;
    localparam int PALM_CODE_W = 4;
    localparam int PALM_PADCTL_W = 8;
    localparam int PALM_ROUTES = 15;
    typedef logic [PALM_CODE_W-1:0] palm_code_t;
    // Pad select source codes.
    localparam palm_code_t PALM_PAD_GPIO = 4'h0;
    localparam palm_code_t PALM_PAD_ALT1 = 4'h1;
    localparam palm_code_t PALM_PAD_ALT2 = 4'h2;
    localparam palm_code_t PALM_PAD_ALT3 = 4'h3;
    localparam palm_code_t PALM_PAD_RST = 4'h0;
    localparam logic [PALM_PADCTL_W-1:0] PALM_PADCTL_RST = 8'h00;
    // Input route codes.
    localparam palm_code_t PALM_RT_OFF = 4'h0;
    localparam palm_code_t PALM_RT_C1 = 4'h1;
    localparam palm_code_t PALM_RT_C2 = 4'h2;
    localparam palm_code_t PALM_RT_RST = 4'h0;
    // Route indices.
    localparam int RT_SCK_IN = 0;
    localparam int RT_TMR0_IN = 1;
    localparam int RT_IRQ0 = 2;
    localparam int RT_TMR1_IN = 3;
    localparam int RT_IRQ1 = 4;
    localparam int RT_BOOT1 = 5;
    localparam int RT_SDI = 6;
    localparam int RT_TMR2_IN = 7;
    localparam int RT_PWMA3_IN = 8;
    localparam int RT_IRQ2 = 9;
    localparam int RT_BOOT2 = 10;
    localparam int RT_TMR3_IN = 11;
    localparam int RT_CSEL_IN = 12;
    localparam int RT_PWMB3_IN = 13;
    localparam int RT_IRQ3 = 14;
    typedef enum logic {PALM_NORMAL, PALM_TRACE} palm_mode_e;
endpackage

// ===== core/palm_top.sv
// Top of the port A low pin multiplexer; all outputs registered.
// Overview of operation
// R1: Each pin has own pad select register.
// R2: Each peripheral input has own route register.
// R3: Connected trace tool overrides pad select.
// R4: Pin 0: gpio, timer ch0, serial clock.
// R5: Pin 0 feeds clock, timer0, irq0 inputs.
// R6: Pin 1: gpio, timer ch1, serial data out.
// R7: Pin 1 feeds timer1 and irq1 inputs.
// R8: Pin 2: gpio, timer ch2, pwm primary ch3.
// R9: Pin 2 feeds boot bit1 at code zero.
// R10: Pin 2 feeds data, timer2, pwm, irq2.
// R11: Pin 3: gpio, timer3, chip select, pwm secondary.
// R12: Pin 3 feeds boot bit2 and timer3 input.
// R13: Pin 3 feeds chip select, pwm, irq3.
// R14: Reserved codes drive nothing, deliver inactive.
// Assumes pad inputs synchronous to clk; one cycle of register latency is accepted.
`timescale 1ns/1ps
module palm_top
    import palm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [PALM_PINS-1:0] padWe,
    input wire logic [PALM_CODE_W-1:0] padWdata,
    input wire logic [PALM_ROUTES-1:0] routeWe,
    input wire logic [PALM_CODE_W-1:0] routeWdata,
    input wire logic traceConnected,
    input wire logic [PALM_PINS-1:0] traceMask,
    input wire logic [PALM_PINS-1:0] traceOut,
    input wire logic [PALM_PINS-1:0] gpioOut,
    input wire logic [PALM_PINS-1:0] gpioOe,
    input wire logic [PALM_PINS-1:0] alt1Out,
    input wire logic [PALM_PINS-1:0] alt1Oe,
    input wire logic [PALM_PINS-1:0] alt2Out,
    input wire logic [PALM_PINS-1:0] alt2Oe,
    input wire logic [PALM_PINS-1:0] alt3Out,
    input wire logic [PALM_PINS-1:0] alt3Oe,
    input wire logic [PALM_PINS-1:0] padIn,
    output logic [PALM_PINS-1:0] padOut,
    output logic [PALM_PINS-1:0] padOeN,
    output logic [PALM_ROUTES-1:0] periphIn
);
    palm_cfg_if cfg ();
    logic [PALM_PINS-1:0] muxOut, muxDrive;
    logic [PALM_ROUTES-1:0] muxIn;
    logic [PALM_PINS-1:0] padOut_reg, padOut_next, padOeN_reg, padOeN_next;
    logic [PALM_ROUTES-1:0] periph_reg, periph_next;

    palm_cfg_regs uRegs (
        .clk(clk),
        .sys_rst(sys_rst),
        .padWe(padWe),
        .padWdata(padWdata),
        .routeWe(routeWe),
        .routeWdata(routeWdata),
        .traceConnected(traceConnected),
        .traceMask(traceMask),
        .cfg(cfg.regs)
    );

    palm_mux_core uMux (
        .cfg(cfg.mux),
        .gpioOut(gpioOut),
        .gpioOe(gpioOe),
        .alt1Out(alt1Out),
        .alt1Oe(alt1Oe),
        .alt2Out(alt2Out),
        .alt2Oe(alt2Oe),
        .alt3Out(alt3Out),
        .alt3Oe(alt3Oe),
        .traceOut(traceOut),
        .padIn(padIn),
        .pinOut(muxOut),
        .pinDrive(muxDrive),
        .periphIn(muxIn)
    );

    always_comb begin
        padOut_next = muxOut;
        padOeN_next = ~muxDrive;
        periph_next = muxIn;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            padOut_reg <= '0;
            padOeN_reg <= '1;
            periph_reg <= '0;
        end else begin
            padOut_reg <= padOut_next;
            padOeN_reg <= padOeN_next;
            periph_reg <= periph_next;
        end
    end

    assign padOut = padOut_reg;
    assign padOeN = padOeN_reg;
    assign periphIn = periph_reg;

    a_trace_override: assert property (@(posedge clk) disable iff (sys_rst)
        $past(traceConnected) && traceMask[0] && !$past(sys_rst)
        |=> !padOeN[0] && padOut[0] == $past(traceOut[0]))
        else $error("trace did not own pin"); // R3
    a_reserved_pad: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.traceOwn[2] && cfg.padSel[2] == PALM_PAD_ALT2 |=> padOeN[2])
        else $error("reserved code drove pin"); // R8
    a_gpio_pass: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.traceOwn[1] && cfg.padSel[1] == PALM_PAD_GPIO
        |=> padOeN[1] == !$past(gpioOe[1]) && padOut[1] == $past(gpioOut[1]))
        else $error("gpio not passed"); // R6
    a_high_reserved: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.traceOwn[3] && cfg.padSel[3] > PALM_PAD_ALT3 |=> padOeN[3] && !padOut[3])
        else $error("reserved pad active"); // R14
    a_alt1_pin0: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.traceOwn[0] && cfg.padSel[0] == PALM_PAD_ALT1
        |=> padOut[0] == $past(alt1Out[0]))
        else $error("timer ch0 not routed"); // R4
    a_serial_clk: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.route[RT_SCK_IN] == PALM_RT_C1 |=> periphIn[RT_SCK_IN] == $past(padIn[0]))
        else $error("serial clock not routed"); // R5
    a_irq1_route: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.route[RT_IRQ1] == PALM_RT_C1 |=> periphIn[RT_IRQ1] == $past(padIn[1]))
        else $error("irq1 not routed"); // R7
    a_boot1_dflt: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.route[RT_BOOT1] == PALM_RT_OFF |=> periphIn[RT_BOOT1] == $past(padIn[2]))
        else $error("boot bit1 not routed"); // R9
    a_tmr2_route: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.route[RT_TMR2_IN] != PALM_RT_C2 |=> !periphIn[RT_TMR2_IN])
        else $error("timer2 input leaked"); // R10
    a_pwm_second: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg.traceOwn[3] && cfg.padSel[3] == PALM_PAD_ALT3
        |=> padOut[3] == $past(alt3Out[3]))
        else $error("pwm secondary not routed"); // R11
    a_tmr3_route: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.route[RT_TMR3_IN] == PALM_RT_C2 |=> periphIn[RT_TMR3_IN] == $past(padIn[3]))
        else $error("timer3 not routed"); // R12
    a_irq3_route: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.route[RT_IRQ3] == PALM_RT_C1 |=> periphIn[RT_IRQ3] == $past(padIn[3]))
        else $error("irq3 not routed"); // R13

    c_trace: cover property (@(posedge clk) traceConnected && traceMask != '0);
    c_alt2_pin1: cover property (@(posedge clk) cfg.padSel[1] == PALM_PAD_ALT2);
    c_irq0: cover property (@(posedge clk) periphIn[RT_IRQ0]);
endmodule

// ===== test/palm_periph_model.sv
// Stand-in for the on-chip peripherals and the package pads around the pin mux.
// Assumes the bench steps pat at falling edges; no two pad select sources share a data or a drive function of pat.
`timescale 1ns/1ps
module palm_periph_model
    import palm_pkg::*;
(
    input wire logic [PALM_PINS-1:0] pat,
    output logic [PALM_PINS-1:0] gpioOut,
    output logic [PALM_PINS-1:0] gpioOe,
    output logic [PALM_PINS-1:0] alt1Out,
    output logic [PALM_PINS-1:0] alt1Oe,
    output logic [PALM_PINS-1:0] alt2Out,
    output logic [PALM_PINS-1:0] alt2Oe,
    output logic [PALM_PINS-1:0] alt3Out,
    output logic [PALM_PINS-1:0] alt3Oe,
    output logic [PALM_PINS-1:0] traceOut,
    output logic [PALM_PINS-1:0] padIn
);
    // Each source differs in data and drive so a wrong pick shows on some pin.
    assign gpioOut = pat ^ 4'h3;
    assign gpioOe = pat;
    assign alt1Out = pat ^ 4'h5;
    assign alt1Oe = ~pat;
    assign alt2Out = pat ^ 4'h6;
    assign alt2Oe = pat ^ 4'h5;
    assign alt3Out = pat ^ 4'h9;
    assign alt3Oe = pat ^ 4'ha;
    assign traceOut = ~pat;
    assign padIn = pat;
endmodule

// ===== test/palm_top_test.sv
// Self-checking bench for the port A low pin mux.
// Assumes the peripheral model in palm_periph_model and the design package palm_pkg.
`timescale 1ns/1ps
module palm_top_test;
    import palm_pkg::*;
    logic clk, sys_rst, traceConnected;
    logic [PALM_PINS-1:0] padWe, traceMask, pat;
    logic [PALM_CODE_W-1:0] padWdata, routeWdata;
    logic [PALM_ROUTES-1:0] routeWe, periphIn;
    logic [PALM_PINS-1:0] gpioOut, gpioOe, alt1Out, alt1Oe, alt2Out, alt2Oe;
    logic [PALM_PINS-1:0] alt3Out, alt3Oe, traceOut, padIn, padOut, padOeN;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    logic [3:0] padValid [4] = '{4'b0111, 4'b0111, 4'b1011, 4'b1111};
    int rtPin [PALM_ROUTES] = '{0, 0, 0, 1, 1, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3};
    int rtCode [PALM_ROUTES] = '{1, 2, 1, 2, 1, 0, 2, 2, 1, 1, 0, 2, 1, 1, 1};

    palm_periph_model i_palm_periph_model (.pat(pat), .gpioOut(gpioOut), .gpioOe(gpioOe),
        .alt1Out(alt1Out), .alt1Oe(alt1Oe), .alt2Out(alt2Out), .alt2Oe(alt2Oe),
        .alt3Out(alt3Out), .alt3Oe(alt3Oe), .traceOut(traceOut), .padIn(padIn));
    palm_top i_palm_top (.clk(clk), .sys_rst(sys_rst), .padWe(padWe), .padWdata(padWdata),
        .routeWe(routeWe), .routeWdata(routeWdata), .traceConnected(traceConnected),
        .traceMask(traceMask), .traceOut(traceOut), .gpioOut(gpioOut), .gpioOe(gpioOe),
        .alt1Out(alt1Out), .alt1Oe(alt1Oe), .alt2Out(alt2Out), .alt2Oe(alt2Oe),
        .alt3Out(alt3Out), .alt3Oe(alt3Oe), .padIn(padIn), .padOut(padOut),
        .padOeN(padOeN), .periphIn(periphIn));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            $display("FAIL at %0t: run did not finish in time", $time);
            close_out();
        end
    end

    task automatic chk(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // A write lands on the next edge and shows two edges later.
    task automatic wr_pad(input int pin, input logic [3:0] code);
        padWdata = code;
        padWe = 4'h1 << pin;
        @(negedge clk);
        padWe = 4'h0;
        repeat (2) @(negedge clk);
    endtask

    task automatic wr_route(input int idx, input logic [3:0] code);
        routeWdata = code;
        routeWe = 15'h0001 << idx;
        @(negedge clk);
        routeWe = 15'h0000;
        repeat (2) @(negedge clk);
    endtask

    task automatic set_pat(input logic [3:0] p);
        pat = p;
        @(negedge clk);
    endtask

    task automatic test_reset();
        chk(padOeN === 4'hf, 1'b1, "pads undriven in reset");
        chk(periphIn === 15'h0000, 1'b1, "inputs quiet in reset");
        sys_rst = 1'b0;
        set_pat(4'hc);
        @(negedge clk);
        chk(periphIn[RT_BOOT1], padIn[2], "boot bit1 default route");
        chk(periphIn[RT_BOOT2], padIn[3], "boot bit2 default route");
        chk(padOeN[1], ~gpioOe[1], "gpio default drive");
        $display("reset test done");
    endtask

    task automatic test_pads();
        logic [3:0] o, e;
        logic ok;
        for (int p = 0; p < PALM_PINS; p++) begin
            for (int c = 0; c < 5; c++) begin
                wr_pad(p, 4'(c));
                for (int k = 0; k < 2; k++) begin
                    set_pat(k ? 4'hf : 4'h0);
                    case (c)
                        0: begin o = gpioOut; e = gpioOe; end
                        1: begin o = alt1Out; e = alt1Oe; end
                        2: begin o = alt2Out; e = alt2Oe; end
                        3: begin o = alt3Out; e = alt3Oe; end
                        default: begin o = 4'h0; e = 4'h0; end
                    endcase
                    ok = (c < 4) && padValid[p][c];
                    chk(padOeN[p], ~(ok & e[p]), "pad drive");
                    if (!ok || e[p]) chk(padOut[p], ok & o[p], "pad data");
                end
            end
            wr_pad(p, PALM_PAD_GPIO);
        end
        $display("pad select test done");
    endtask

    task automatic test_routes();
        for (int r = 0; r < PALM_ROUTES; r++) begin
            for (int c = 0; c < 4; c++) begin
                wr_route(r, 4'(c));
                for (int k = 0; k < 2; k++) begin
                    set_pat(k ? 4'hf : 4'h0);
                    chk(periphIn[r], (c == rtCode[r]) & padIn[rtPin[r]],
                        "route input");
                end
            end
        end
        $display("input route test done");
    endtask

    task automatic test_trace();
        wr_pad(0, 4'h3);
        traceMask = 4'h9;
        traceConnected = 1'b1;
        repeat (2) @(negedge clk);
        for (int k = 0; k < 2; k++) begin
            set_pat(k ? 4'h5 : 4'ha);
            for (int p = 0; p < PALM_PINS; p++) begin
                if (traceMask[p]) begin
                    chk(padOeN[p], 1'b0, "trace drive");
                    chk(padOut[p], traceOut[p], "trace data");
                end else begin
                    chk(padOeN[p], ~gpioOe[p], "untraced pin drive");
                end
            end
        end
        traceConnected = 1'b0;
        repeat (2) @(negedge clk);
        chk(padOeN[0], 1'b1, "reserved pin free after trace");
        $display("trace test done");
    endtask

    initial begin
        sys_rst = 1'b1;
        padWe = 4'h0;
        padWdata = 4'h0;
        routeWe = 15'h0000;
        routeWdata = 4'h0;
        traceConnected = 1'b0;
        traceMask = 4'h0;
        pat = 4'h0;
        repeat (2) @(negedge clk);
        test_reset();
        test_pads();
        test_routes();
        test_trace();
        close_out();
    end
endmodule
